// ===== rtl/exec_pkg.sv
// Shared constants and types for the OR, shift, move and indirect-load unit
package exec_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 16;
   localparam int FILE_W = 7;
   localparam int OFF_W = 6;
   localparam int MSB = 7;
   localparam int NUM_PTR = 2;
   // File addresses that stand for the indirect access location of each pointer
   localparam logic [6:0] INDIRECT_ADDR0 = 7'h00;
   localparam logic [6:0] INDIRECT_ADDR1 = 7'h01;
   // Pointer modify mode codes
   localparam logic [1:0] MODE_PRE_INC = 2'h0;
   localparam logic [1:0] MODE_PRE_DEC = 2'h1;
   localparam logic [1:0] MODE_POST_INC = 2'h2;
   localparam logic [1:0] MODE_POST_DEC = 2'h3;
   localparam logic [15:0] PTR_STEP = 16'h0001;
   // Destination bit values
   localparam logic DEST_WORK = 1'b0;
   localparam logic DEST_FILE = 1'b1;
   // Reset values
   localparam logic [7:0] WORK_RST = 8'h00;
   localparam logic [15:0] PTR_RST = 16'h0000;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   typedef enum logic [2:0] {
      OP_OR_W_WITH_FILE = 3'b000,
      OP_LOGICAL_SHIFT_LEFT_FILE = 3'b001,
      OP_LOGICAL_SHIFT_RIGHT_FILE = 3'b010,
      OP_MOVE_FILE = 3'b011,
      OP_MOVE_INDIRECT_TO_WORK = 3'b100
   } op_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_EXEC = 2'b10
   } state_e;
endpackage : exec_pkg

// ===== rtl/or_shift_move_indirect_exec.sv
// Execution unit for OR, logical shifts, file move and indirect load
`timescale 1ns/1ns
`default_nettype none
module or_shift_move_indirect_exec (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Operation request from the decoder
   input wire logic op_valid,
   input wire exec_pkg::op_e op_code,
   input wire logic [exec_pkg::FILE_W-1:0] file_addr,
   input wire logic dest_sel,
   input wire logic ptr_index,
   input wire logic relative_form,
   input wire logic [1:0] pointer_modify_mode,
   input wire logic [exec_pkg::OFF_W-1:0] rel_offset,
   output logic op_ready,
   output logic op_done,
   // Direct loads of work register and pointers
   input wire logic work_load,
   input wire logic [exec_pkg::DATA_W-1:0] work_load_val,
   input wire logic ptr_load,
   input wire logic ptr_load_sel,
   input wire logic [exec_pkg::ADDR_W-1:0] ptr_load_val,
   // Data memory
   output logic mem_rd_en,
   output logic mem_wr_en,
   output logic [exec_pkg::ADDR_W-1:0] mem_addr,
   output logic [exec_pkg::DATA_W-1:0] mem_wdata,
   input wire logic [exec_pkg::DATA_W-1:0] mem_rdata,
   // Core state
   output logic [exec_pkg::DATA_W-1:0] work_reg,
   output logic carry_flag,
   output logic zero_flag,
   output logic [exec_pkg::ADDR_W-1:0] file_select_pointer0,
   output logic [exec_pkg::ADDR_W-1:0] file_select_pointer1
);
   import exec_pkg::*;

   typedef struct packed {
      state_e state;
      op_e op;
      logic dest;
      logic [DATA_W-1:0] work;
      logic carry;
      logic zero;
      logic [NUM_PTR-1:0][ADDR_W-1:0] ptr;
      logic rd;
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] res;
      logic done;
   } exec_s;

   exec_s st_r;
   exec_s st_nxt;

   // Maps a file address onto a data address, redirecting the indirect location
   function automatic logic [ADDR_W-1:0] file_to_addr(
      input logic [FILE_W-1:0] fa,
      input logic [NUM_PTR-1:0][ADDR_W-1:0] p
   );
      logic [ADDR_W-1:0] a;
      a = {{(ADDR_W-FILE_W){1'b0}}, fa};
      if (fa == INDIRECT_ADDR0) begin
         a = p[0];
      end else if (fa == INDIRECT_ADDR1) begin
         a = p[1];
      end
      return a;
   endfunction : file_to_addr

   // Pointer after the modify mode is applied
   function automatic logic [ADDR_W-1:0] step_ptr(
      input logic [ADDR_W-1:0] p,
      input logic [1:0] m
   );
      logic [ADDR_W-1:0] q;
      q = p + PTR_STEP;
      if (m == MODE_PRE_DEC || m == MODE_POST_DEC) begin
         q = p - PTR_STEP;
      end
      return q;
   endfunction : step_ptr

   logic [ADDR_W-1:0] sel_ptr;
   logic [ADDR_W-1:0] rel_ext;
   logic [DATA_W-1:0] alu_res;
   logic alu_carry;

   assign sel_ptr = st_r.ptr[ptr_index];
   assign rel_ext = {{(ADDR_W-OFF_W){rel_offset[OFF_W-1]}}, rel_offset};

   // Result and carry from the fetched operand
   always_comb begin
      alu_res = mem_rdata;
      alu_carry = st_r.carry;
      unique case (st_r.op)
         OP_OR_W_WITH_FILE: alu_res = st_r.work | mem_rdata;
         OP_LOGICAL_SHIFT_LEFT_FILE: begin
            alu_res = {mem_rdata[MSB-1:0], 1'b0};
            alu_carry = mem_rdata[MSB];
         end
         OP_LOGICAL_SHIFT_RIGHT_FILE: begin
            alu_res = {1'b0, mem_rdata[MSB:1]};
            alu_carry = mem_rdata[0];
         end
         OP_MOVE_FILE: alu_res = mem_rdata;
         OP_MOVE_INDIRECT_TO_WORK: alu_res = mem_rdata;
      endcase
   end

   // Next-state logic
   always_comb begin
      st_nxt = st_r;
      st_nxt.rd = 1'b0;
      st_nxt.wr = 1'b0;
      st_nxt.done = 1'b0;
      if (work_load) begin
         st_nxt.work = work_load_val;
      end
      if (ptr_load) begin
         st_nxt.ptr[ptr_load_sel] = ptr_load_val;
      end
      unique case (st_r.state)
         ST_IDLE: begin
            if (op_valid) begin
               st_nxt.op = op_code;
               st_nxt.dest = dest_sel;
               st_nxt.rd = 1'b1;
               st_nxt.state = ST_FETCH;
               if (op_code == OP_MOVE_INDIRECT_TO_WORK) begin
                  st_nxt.dest = DEST_WORK;
                  if (relative_form) begin
                     st_nxt.addr = sel_ptr + rel_ext;
                  end else begin
                     st_nxt.ptr[ptr_index] = step_ptr(sel_ptr, pointer_modify_mode);
                     if (pointer_modify_mode == MODE_PRE_INC
                         || pointer_modify_mode == MODE_PRE_DEC) begin
                        st_nxt.addr = step_ptr(sel_ptr, pointer_modify_mode);
                     end else begin
                        st_nxt.addr = sel_ptr;
                     end
                  end
               end else begin
                  st_nxt.addr = file_to_addr(file_addr, st_r.ptr);
               end
            end
         end
         ST_FETCH: st_nxt.state = ST_EXEC;
         ST_EXEC: begin
            st_nxt.state = ST_IDLE;
            st_nxt.done = 1'b1;
            st_nxt.res = alu_res;
            st_nxt.zero = (alu_res == ZERO_BYTE);
            st_nxt.carry = alu_carry;
            if (st_r.dest == DEST_FILE) begin
               st_nxt.wr = 1'b1;
               st_nxt.wdata = alu_res;
            end else begin
               st_nxt.work = alu_res;
            end
         end
         default: st_nxt.state = ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '{state: ST_IDLE, op: OP_OR_W_WITH_FILE, dest: DEST_WORK,
                   work: WORK_RST, carry: 1'b0, zero: 1'b0,
                   ptr: {PTR_RST, PTR_RST}, rd: 1'b0, wr: 1'b0,
                   addr: PTR_RST, wdata: ZERO_BYTE, res: ZERO_BYTE, done: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs
   assign op_ready = (st_r.state == ST_IDLE);
   assign op_done = st_r.done;
   assign mem_rd_en = st_r.rd;
   assign mem_wr_en = st_r.wr;
   assign mem_addr = st_r.addr;
   assign mem_wdata = st_r.wdata;
   assign work_reg = st_r.work;
   assign carry_flag = st_r.carry;
   assign zero_flag = st_r.zero;
   assign file_select_pointer0 = st_r.ptr[0];
   assign file_select_pointer1 = st_r.ptr[1];

   // Checks
   logic in_exec;
   logic take_ind;
   assign in_exec = (st_r.state == ST_EXEC);
   assign take_ind = op_ready && op_valid && op_code == OP_MOVE_INDIRECT_TO_WORK
                     && !ptr_load;

   property p_or_result;
      @(posedge clk) disable iff (!rstn)
      in_exec && st_r.op == OP_OR_W_WITH_FILE && !st_r.dest && !work_load
      |=> work_reg == $past(st_r.work | mem_rdata);
   endproperty
   a_or_result: assert property (p_or_result) else $error("OR result wrong");

   property p_dest_file;
      @(posedge clk) disable iff (!rstn)
      in_exec && st_r.dest |=> mem_wr_en && mem_addr == $past(mem_addr)
      && mem_wdata == $past(alu_res);
   endproperty
   a_dest_file: assert property (p_dest_file) else $error("File write missing");

   property p_shl;
      @(posedge clk) disable iff (!rstn)
      in_exec && st_r.op == OP_LOGICAL_SHIFT_LEFT_FILE
      |=> carry_flag == $past(mem_rdata[7]) && st_r.res == {$past(mem_rdata[6:0]), 1'b0};
   endproperty
   a_shl: assert property (p_shl) else $error("Left shift wrong");

   property p_shr;
      @(posedge clk) disable iff (!rstn)
      in_exec && st_r.op == OP_LOGICAL_SHIFT_RIGHT_FILE
      |=> carry_flag == $past(mem_rdata[0]) && st_r.res == {1'b0, $past(mem_rdata[7:1])};
   endproperty
   a_shr: assert property (p_shr) else $error("Right shift wrong");

   property p_move_timing;
      @(posedge clk) disable iff (!rstn)
      op_ready && op_valid |=> mem_rd_en ##2 op_done;
   endproperty
   a_move_timing: assert property (p_move_timing) else $error("Op latency wrong");

   property p_ind_to_work;
      @(posedge clk) disable iff (!rstn)
      take_ind ##3 !work_load[*1] |-> work_reg == $past(mem_rdata, 1) && !mem_wr_en;
   endproperty
   a_ind_to_work: assert property (p_ind_to_work) else $error("Indirect load wrong");

   property p_pre_inc;
      @(posedge clk) disable iff (!rstn)
      take_ind && !relative_form && pointer_modify_mode == MODE_PRE_INC
      |=> mem_addr == $past(sel_ptr) + PTR_STEP && st_r.ptr[$past(ptr_index)] == mem_addr;
   endproperty
   a_pre_inc: assert property (p_pre_inc) else $error("Pre-increment wrong");

   property p_post_dec;
      @(posedge clk) disable iff (!rstn)
      take_ind && !relative_form && pointer_modify_mode == MODE_POST_DEC
      |=> mem_addr == $past(sel_ptr) && st_r.ptr[$past(ptr_index)] == mem_addr - PTR_STEP;
   endproperty
   a_post_dec: assert property (p_post_dec) else $error("Post-decrement wrong");

   property p_relative;
      @(posedge clk) disable iff (!rstn)
      take_ind && relative_form
      |=> mem_addr == $past(sel_ptr) + $past(rel_ext) && $stable(st_r.ptr);
   endproperty
   a_relative: assert property (p_relative) else $error("Relative form wrong");

   property p_redirect;
      @(posedge clk) disable iff (!rstn)
      op_ready && op_valid && op_code != OP_MOVE_INDIRECT_TO_WORK
      && file_addr == INDIRECT_ADDR1 |=> mem_addr == $past(st_r.ptr[1]);
   endproperty
   a_redirect: assert property (p_redirect) else $error("Indirect not redirected");

   property p_zero;
      @(posedge clk) disable iff (!rstn)
      in_exec |=> zero_flag == ((st_r.dest ? mem_wdata : work_reg) == ZERO_BYTE);
   endproperty
   a_zero: assert property (p_zero) else $error("Zero flag wrong");

   c_or_to_file: cover property (@(posedge clk) disable iff (!rstn)
      in_exec && st_r.op == OP_OR_W_WITH_FILE && st_r.dest);
   c_wrap: cover property (@(posedge clk) disable iff (!rstn)
      take_ind && !relative_form && pointer_modify_mode == MODE_PRE_INC
      && sel_ptr == 16'hFFFF);
   c_neg_offset: cover property (@(posedge clk) disable iff (!rstn)
      take_ind && relative_form && rel_offset[OFF_W-1]);
endmodule : or_shift_move_indirect_exec
`default_nettype wire

// ===== sim/data_mem_model.sv
// Data memory model that answers the unit's reads and takes its writes
`timescale 1ns/1ns
`default_nettype none
module data_mem_model (
   // Clock
   input wire logic clk,
   // Access from the unit
   input wire logic mem_rd_en,
   input wire logic mem_wr_en,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   output var logic [7:0] mem_rdata
);
   logic [7:0] mem [0:65535];
   // Read data holds one cycle, then is inverted on every cycle without a read, so stale data matches only every other cycle
   always @(posedge clk) begin
      if (mem_rd_en) begin
         mem_rdata <= mem[mem_addr];
      end else begin
         mem_rdata <= ~mem_rdata;
      end
      if (mem_wr_en) begin
         mem[mem_addr] <= mem_wdata;
      end
   end
endmodule : data_mem_model
`default_nettype wire

// ===== sim/or_shift_move_indirect_exec_tb.sv
// Self-checking bench for the OR, shift, move and indirect-load unit
`timescale 1ns/1ns
`default_nettype none
module or_shift_move_indirect_exec_tb;
   import exec_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic op_valid = 1'b0;
   op_e op_code = OP_OR_W_WITH_FILE;
   logic [6:0] file_addr = 7'h00;
   logic dest_sel = 1'b0;
   logic ptr_index = 1'b0;
   logic relative_form = 1'b0;
   logic [1:0] pointer_modify_mode = 2'h0;
   logic [5:0] rel_offset = 6'h00;
   logic work_load = 1'b0;
   logic [7:0] work_load_val = 8'h00;
   logic ptr_load = 1'b0;
   logic ptr_load_sel = 1'b0;
   logic [15:0] ptr_load_val = 16'h0000;
   logic op_ready, op_done, mem_rd_en, mem_wr_en, carry_flag, zero_flag;
   logic [15:0] mem_addr, file_select_pointer0, file_select_pointer1;
   logic [7:0] mem_wdata, mem_rdata, work_reg;
   logic [7:0] w_exp = 8'h00;
   int n_errors = 0;
   int cmp_count = 0;
   // Clock generator
   initial begin
      forever #5 clk = ~clk;
   end
   or_shift_move_indirect_exec u_dut (.clk(clk), .rstn(rstn), .op_valid(op_valid),
      .op_code(op_code), .file_addr(file_addr), .dest_sel(dest_sel), .ptr_index(ptr_index),
      .relative_form(relative_form), .pointer_modify_mode(pointer_modify_mode),
      .rel_offset(rel_offset), .op_ready(op_ready), .op_done(op_done),
      .work_load(work_load), .work_load_val(work_load_val), .ptr_load(ptr_load),
      .ptr_load_sel(ptr_load_sel), .ptr_load_val(ptr_load_val), .mem_rd_en(mem_rd_en),
      .mem_wr_en(mem_wr_en), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .work_reg(work_reg), .carry_flag(carry_flag),
      .zero_flag(zero_flag), .file_select_pointer0(file_select_pointer0),
      .file_select_pointer1(file_select_pointer1));
   data_mem_model u_mem (.clk(clk), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   // Verdict and end of run
   task automatic print_verdict();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict
   // Compare one value
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Direct loads of work register and pointer
   task automatic set_work(input logic [7:0] v);
      work_load <= 1'b1;
      work_load_val <= v;
      w_exp = v;
      @(posedge clk);
      work_load <= 1'b0;
   endtask : set_work
   task automatic set_ptr(input logic s, input logic [15:0] v);
      ptr_load <= 1'b1;
      ptr_load_sel <= s;
      ptr_load_val <= v;
      @(posedge clk);
      ptr_load <= 1'b0;
   endtask : set_ptr
   // One operation: preload memory, request, wait for done, check results
   // Control word packs destination, pointer index, relative form and mode
   task automatic run(input op_e op, input logic [6:0] fa, input logic [4:0] ctl,
      input logic [5:0] off, input logic [15:0] ea,
      input logic [7:0] mv, input logic [7:0] res, input logic cy);
      int n;
      logic d;
      d = ctl[4];
      u_mem.mem[ea] = mv;
      op_valid <= 1'b1;
      op_code <= op;
      file_addr <= fa;
      dest_sel <= d;
      ptr_index <= ctl[3];
      relative_form <= ctl[2];
      pointer_modify_mode <= ctl[1:0];
      rel_offset <= off;
      n = 0;
      @(negedge clk);
      while (op_ready !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      if (n >= 20) begin
         chk(16'h0000, 16'h0001);
         print_verdict();
      end
      @(posedge clk);
      op_valid <= 1'b0;
      do begin
         @(negedge clk);
         n++;
      end while (op_done !== 1'b1 && n < 40);
      if (n >= 40) begin
         chk(16'h0000, 16'h0001);
         print_verdict();
      end
      if (d == DEST_WORK) begin
         w_exp = res;
      end
      chk(mem_addr, ea);
      chk(work_reg, w_exp);
      chk(zero_flag, res == 8'h00);
      chk(carry_flag, cy);
      chk(mem_wr_en, d);
      if (d == DEST_FILE) begin
         chk(mem_wdata, res);
      end
      @(posedge clk);
   endtask : run
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk(work_reg, 16'h0000);
      chk(file_select_pointer0, 16'h0000);
      chk(op_ready, 16'h0001);
      set_work(8'h0F);
      run(OP_OR_W_WITH_FILE, 7'h10, 5'b00000, 6'h00, 16'h0010, 8'hF0, 8'hFF, 1'b0);
      set_work(8'h00);
      run(OP_OR_W_WITH_FILE, 7'h7F, 5'b10000, 6'h00, 16'h007F, 8'h00, 8'h00, 1'b0);
      run(OP_LOGICAL_SHIFT_LEFT_FILE, 7'h20, 5'b00000, 6'h00, 16'h0020, 8'h81, 8'h02, 1'b1);
      run(OP_LOGICAL_SHIFT_LEFT_FILE, 7'h21, 5'b10000, 6'h00, 16'h0021, 8'h80, 8'h00, 1'b1);
      run(OP_LOGICAL_SHIFT_RIGHT_FILE, 7'h22, 5'b00000, 6'h00, 16'h0022, 8'hFE, 8'h7F,
         1'b0);
      run(OP_LOGICAL_SHIFT_RIGHT_FILE, 7'h23, 5'b10000, 6'h00, 16'h0023, 8'h01, 8'h00,
         1'b1);
      run(OP_MOVE_FILE, 7'h7F, 5'b10000, 6'h00, 16'h007F, 8'h00, 8'h00, 1'b1);
      run(OP_MOVE_FILE, 7'h40, 5'b00000, 6'h00, 16'h0040, 8'h3C, 8'h3C, 1'b1);
      set_ptr(1'b0, 16'hFFFF);
      run(OP_MOVE_INDIRECT_TO_WORK, 7'h00, 5'b00000, 6'h00, 16'h0000, 8'h11, 8'h11, 1'b1);
      chk(file_select_pointer0, 16'h0000);
      run(OP_MOVE_INDIRECT_TO_WORK, 7'h00, 5'b00001, 6'h00, 16'hFFFF, 8'h00, 8'h00, 1'b1);
      chk(file_select_pointer0, 16'hFFFF);
      run(OP_MOVE_INDIRECT_TO_WORK, 7'h00, 5'b00010, 6'h00, 16'hFFFF, 8'h22, 8'h22, 1'b1);
      chk(file_select_pointer0, 16'h0000);
      run(OP_MOVE_INDIRECT_TO_WORK, 7'h00, 5'b00011, 6'h00, 16'h0000, 8'h33, 8'h33, 1'b1);
      chk(file_select_pointer0, 16'hFFFF);
      set_ptr(1'b1, 16'h1000);
      run(OP_MOVE_INDIRECT_TO_WORK, 7'h00, 5'b01100, 6'h20, 16'h0FE0, 8'h44, 8'h44, 1'b1);
      run(OP_MOVE_INDIRECT_TO_WORK, 7'h00, 5'b01111, 6'h1F, 16'h101F, 8'h55, 8'h55, 1'b1);
      chk(file_select_pointer1, 16'h1000);
      chk(file_select_pointer0, 16'hFFFF);
      run(OP_MOVE_FILE, 7'h01, 5'b00000, 6'h00, 16'h1000, 8'h66, 8'h66, 1'b1);
      run(OP_OR_W_WITH_FILE, 7'h00, 5'b10000, 6'h00, 16'hFFFF, 8'h80, 8'hE6, 1'b1);
      print_verdict();
   end
endmodule : or_shift_move_indirect_exec_tb
`default_nettype wire
